// *** dv/pisc_seq_model.sv ***
// model of the input units and the program sequencer
// assumes svc pulses on pclk; the bench sets request bits and routine length
`timescale 1ns/1ps
`default_nettype none
module pisc_seq_model (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // bench side
  input  wire logic [7:0]           run_len,
  input  wire logic [3:0][7:0]      req_bits,
  output logic [15:0]               go_cnt,
  output logic [6:0]                last_go,
  output logic [15:0]               res_cnt,
  output logic [6:0]                last_res,
  // controller side
  input  wire pisc_pkg::pisc_svc_t  svc,
  output pisc_pkg::pisc_units_t     units_in,
  output logic                      svc_done
);
  logic [7:0] cnt;
  logic [7:0] noise;
  // ==========================================
  // unit words
  // upper bits toggle every cycle, so any use of them shows as a stray routine
  assign units_in = {noise, req_bits[3], noise, req_bits[2], noise, req_bits[1],
                     noise, req_bits[0]};
  // ==========================================
  // sequencer
  // a preempted routine restarts its full length on resume: simpler, still legal
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {cnt, noise, go_cnt, last_go, res_cnt, last_res, svc_done} <= '0;
    else
    begin
      noise    <= ~noise;
      svc_done <= 1'b0;
      if (svc.go)
      begin
        go_cnt  <= go_cnt + 16'h0001;
        last_go <= svc.num;
        cnt     <= run_len;
      end
      else if (svc.resume)
      begin
        res_cnt  <= res_cnt + 16'h0001;
        last_res <= svc.num;
        cnt      <= run_len;
      end
      else if (cnt == 8'h01)
      begin
        svc_done <= 1'b1;
        cnt      <= 8'h00;
      end
      else if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** dv/plc_interrupt_and_schedule_ctrl_tb_top.sv ***
// self-checking bench for the interrupt and schedule controller
// assumes pisc_pkg and the sequencer model are compiled before it
`timescale 1ns/1ps
`include "pisc_consts.svh"
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module plc_interrupt_and_schedule_ctrl_tb_top;
  // ==========================================
  // signals
  // short tick keeps the timer scenarios to a few hundred cycles
  localparam int T = 5;
  localparam logic [25:0] BAD [0:6] = '{
    {4'h5, 4'h0, 2'b01, 16'h00ff}, {4'h0, 4'h3, 2'b01, 16'h00ff},
    {4'h0, 4'h2, 2'b01, 16'h00ff}, {4'h4, 4'h0, 2'b01, 16'h00a0},
    {4'h0, 4'h0, 2'b11, 16'h00ff}, {4'h0, 4'h0, 2'b10, 16'h1000},
    {4'h0, 4'h0, 2'b10, 16'h00a0}};
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata, rdv;
  logic                  pready, pslverr, errv, svc_done, error_flag;
  pisc_pkg::pisc_units_t units_in;
  pisc_pkg::pisc_svc_t   svc;
  logic [7:0]            run_len = 8'h02;
  logic [3:0][7:0]       req_bits = '0;
  logic [15:0]           go_cnt, res_cnt, g;
  logic [6:0]            last_go, last_res;
  int                    fail_count = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  int                    tlast = 0;
  int                    dt = 0;
  pisc_ctrl #(.TICK_CYCLES(T)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .units_in(units_in), .svc_done(svc_done),
    .svc(svc), .error_flag(error_flag));
  pisc_seq_model model (.pclk(pclk), .presetn(presetn), .run_len(run_len),
    .req_bits(req_bits), .go_cnt(go_cnt), .last_go(last_go), .res_cnt(res_cnt),
    .last_res(last_res), .svc(svc), .units_in(units_in), .svc_done(svc_done));
  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  initial
  begin
    wait (cyc == 20000);
    fail_count++;
    finish_test();
  end
  // ==========================================
  // tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv     = prdata;
    errv    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [3:0] s, input logic [3:0] c, input logic [1:0] m,
                     input logic [15:0] v);
    bus(1'b1, `PISC_OFS_OPER, {16'h0000, v});
    bus(1'b1, `PISC_OFS_CMD, {22'h000000, m, c, s});
  endtask
  task automatic wait_go(input logic [15:0] base, input int lim);
    int n;
    n = 0;
    while (go_cnt === base && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    dt    = cyc - tlast;
    tlast = cyc;
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, `PISC_OFS_MASK, 32'h0);
    `CHK("mask reset", 32'h0, rdv)
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 1'b1, errv)
    for (int u = 0; u < 4; u++)
      for (int b = 0; b < 8; b += 7)
      begin
        req_bits[u][b] <= 1'b1;
        wait_go(go_cnt, 40);
        `CHK("routine", 7'(u * 8 + b), last_go)
        req_bits[u][b] <= 1'b0;
      end
    req_bits[2][3] <= 1'b1;
    req_bits[0][0] <= 1'b1;
    wait_go(go_cnt, 40);
    `CHK("lowest first", 7'h00, last_go)
    wait_go(go_cnt, 40);
    `CHK("then next", 7'h13, last_go)
    req_bits <= '0;
    cmd(4'h1, 4'h0, 2'b01, 16'h0005);
    cmd(4'h1, 4'h2, 2'b00, 16'h0000);
    bus(1'b0, `PISC_OFS_RESULT, 32'h0);
    `CHK("mask read", 32'h5, rdv)
    bus(1'b0, `PISC_OFS_MASK, 32'h0);
    `CHK("mask map", 32'h500, rdv)
    g = go_cnt;
    req_bits[1][0] <= 1'b1;
    req_bits[1][2] <= 1'b1;
    wait_go(g, 30);
    `CHK("masked", g, go_cnt)
    bus(1'b0, `PISC_OFS_PEND, 32'h0);
    `CHK("pending", 32'h500, rdv)
    g = go_cnt;
    cmd(4'h1, 4'h0, 2'b01, 16'h0004);
    wait_go(g, 30);
    `CHK("unmasked", 7'h08, last_go)
    cmd(4'h1, 4'h1, 2'b01, 16'h0000);
    g = go_cnt;
    cmd(4'h1, 4'h0, 2'b01, 16'h0000);
    wait_go(g, 30);
    `CHK("cleared", g, go_cnt)
    req_bits <= '0;
    bus(1'b1, `PISC_OFS_DATA, 32'h00ff);
    for (int i = 0; i < 7; i++)
    begin
      cmd(BAD[i][25:22], BAD[i][21:18], BAD[i][17:16], BAD[i][15:0]);
      `CHK("refused", 1'b1, error_flag)
    end
    bus(1'b0, `PISC_OFS_MASK, 32'h0);
    `CHK("not run", 32'h0, rdv)
    cmd(4'h0, 4'h0, 2'b10, 16'h0999);
    `CHK("accepted", 1'b0, error_flag)
    bus(1'b0, `PISC_OFS_MASK, 32'h0);
    `CHK("indirect", 32'hff, rdv)
    cmd(4'h0, 4'h0, 2'b01, 16'h0000);
    cmd(4'h4, 4'h0, 2'b01, 16'h0003);
    cmd(4'h4, 4'h2, 2'b00, 16'h0000);
    bus(1'b0, `PISC_OFS_RESULT, 32'h0);
    `CHK("interval", 32'h3, rdv)
    g = go_cnt;
    wait_go(g, 20 * T);
    `CHK("unarmed", g, go_cnt)
    g = go_cnt;
    cmd(4'h4, 4'h1, 2'b01, 16'h0002);
    wait_go(g, 4 * T);
    `CHK("first", 7'h63, last_go)
    wait_go(go_cnt, 8 * T);
    `CHK("repeat gap", 3 * T, dt)
    g = go_cnt;
    cmd(4'h4, 4'h0, 2'b01, 16'h0005);
    wait_go(g, 8 * T);
    `CHK("old gap", 3 * T, dt)
    wait_go(go_cnt, 8 * T);
    `CHK("new gap", 5 * T, dt)
    g = go_cnt;
    repeat (4) cmd(4'h4, 4'h1, 2'b01, 16'h0004);
    `CHK("restarted", g, go_cnt)
    cmd(4'h4, 4'h0, 2'b01, 16'h0000);
    wait_go(g, 20 * T);
    `CHK("cancelled", g, go_cnt)
    bus(1'b0, `PISC_OFS_COUNT, 32'h0);
    `CHK("count stopped", 32'h0, rdv)
    run_len <= 8'h3c;
    req_bits[0][1] <= 1'b1;
    wait_go(go_cnt, 40);
    g = res_cnt;
    cmd(4'h4, 4'h1, 2'b01, 16'h0001);
    wait_go(go_cnt, 4 * T);
    `CHK("preempt", 7'h63, last_go)
    bus(1'b0, `PISC_OFS_STATUS, 32'h0);
    `CHK("both active", 32'h10e, rdv)
    while (res_cnt === g) @(posedge pclk);
    `CHK("resume", 7'h01, last_res)
    finish_test();
  end
endmodule
`default_nettype wire

// *** src/pisc_consts.svh ***
// constants of the interrupt and schedule controller
// assumes a 50 MHz pclk and a 32-bit apb register bus
`ifndef PISC_CONSTS_SVH
`define PISC_CONSTS_SVH
// ==========================================
// register byte offsets
`define PISC_OFS_CMD    8'h00
`define PISC_OFS_OPER   8'h04
`define PISC_OFS_DATA   8'h08
`define PISC_OFS_RESULT 8'h0c
`define PISC_OFS_STATUS 8'h10
`define PISC_OFS_COUNT  8'h14
`define PISC_OFS_MASK   8'h18
`define PISC_OFS_PEND   8'h1c
// ==========================================
// command word fields
`define PISC_CMD_SEL  3:0
`define PISC_CMD_CODE 7:4
`define PISC_CMD_IMM  8
`define PISC_CMD_IND  9
// ==========================================
// selectors, control codes, routine numbers
`define PISC_SEL_LAST_UNIT 4'h3
`define PISC_SEL_TIMER     4'h4
`define PISC_CODE_SET      4'h0
`define PISC_CODE_CLEAR    4'h1
`define PISC_CODE_READ     4'h2
`define PISC_ROUTINE_SCHED 7'h63
`define PISC_UNIT_BITS     8
// ==========================================
// timing
`define PISC_CLK_NS  20
`define PISC_TICK_NS 10000000
`define PISC_TICK_CYCLES (`PISC_TICK_NS / `PISC_CLK_NS)
`define PISC_DM_WORDS 1000
`endif

// *** src/pisc_ctrl.sv ***
// interrupt controller: input-unit requests, scheduled timer, apb registers
// assumes irq words from outside pclk, sequencer signals on pclk
// Functional notes
// [RQ1] selector 0..3 picks an input unit, 4 picks the timer
// [RQ2] up to four input units numbered 0 to 3
// [RQ3] only bits 0..7 of each unit request, bits 8..15 ignored
// [RQ4] request bit turning on calls routine unit*8+bit
// [RQ5] code 0 on a unit masks ones and unmasks zeros
// [RQ6] request on masked bit is recorded as pending
// [RQ7] pending masked request is served once unmasked unless cleared
// [RQ8] code 1 on a unit discards its pending requests
// [RQ9] code 2 on a unit returns its mask bits
// [RQ10] immediate operand allowed only for codes 0 and 1
// [RQ11] timer code 0 loads bcd repeat interval in hundredths
// [RQ12] repeat interval zero stops further scheduled interrupts
// [RQ13] new repeat interval used only after next scheduled interrupt
// [RQ14] timer code 1 loads bcd first delay, zero means none
// [RQ15] first delay restarts countdown at once for one period
// [RQ16] every first delay rewrite restarts the countdown
// [RQ17] timer code 2 returns the loaded repeat interval
// [RQ18] routine 99 only after interval and first delay are programmed
// [RQ19] timer counts real time, independent of scan
// [RQ20] bad selector, code or operand sets error, no execution
// [RQ21] bad bcd indirect address or past memory end sets error
// [RQ22] after routine 99 the suspended routine resumes
// [RQ23] requests wait for running routine, lowest number first
// [RQ24] scheduled interrupt preempts an input-unit routine
// [RQ25] timer steps each 10 ms, reloads at zero, raises request
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "pisc_consts.svh"
`default_nettype none
module pisc_ctrl #(
  parameter int NUM_UNITS   = 4,
  parameter int TICK_CYCLES = `PISC_TICK_CYCLES,
  parameter int DM_WORDS    = `PISC_DM_WORDS
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // input units
  input  wire pisc_pkg::pisc_units_t units_in,
  // program sequencer
  input  wire logic                 svc_done,
  output pisc_pkg::pisc_svc_t       svc,
  output logic                      error_flag
);
  // ==========================================
  // parameter checks
  initial
  begin
    if (NUM_UNITS < 1 || NUM_UNITS > 4 || TICK_CYCLES < 1 ||
        TICK_CYCLES > 24'hffffff || DM_WORDS < 1 || DM_WORDS > 9999)
    begin
      $error("pisc_ctrl: unsupported parameter value");
    end
  end

  // ==========================================
  // helpers
  function automatic logic bcd_ok(input logic [15:0] v);
    bcd_ok = v[3:0] < 4'ha && v[7:4] < 4'ha && v[11:8] < 4'ha && v[15:12] < 4'ha;
  endfunction

  function automatic logic [13:0] bcd2bin(input logic [15:0] v);
    // 14-bit terms, a narrower product wraps above 1023
    bcd2bin = v[15:12] * 14'd1000 + v[11:8] * 14'd100 + v[7:4] * 14'd10 + 14'(v[3:0]);
  endfunction

  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
  localparam logic [13:0] DM_LAST   = 14'(DM_WORDS - 1);

  pisc_pkg::pisc_state_t st;
  pisc_pkg::pisc_state_t n;
  logic [31:0] irq_lo;
  logic [31:0] rise;
  logic [31:0] cand;
  logic [31:0] clr_v;
  logic [31:0] hold_v;
  logic [31:0] rd;
  logic        acc;
  logic        wr_cmd;
  logic        cmd_ok;
  logic        bad;
  logic        armed;
  logic        tick;
  logic [3:0]  sel;
  logic [3:0]  code;
  logic [15:0] val;
  logic [4:0]  low_num;
  logic        low_any;

  // ==========================================
  // request inputs, unit words beyond the fitted units read as idle
  always_comb
  begin
    irq_lo = '0;
    for (int u = 0; u < 4; u++)
    begin
      if (u < NUM_UNITS)
      begin
        irq_lo[u*8 +: 8] = units_in.word[u][7:0]; // RQ2 RQ3
      end
    end
  end

  // ==========================================
  // decode and operand checks
  always_comb
  begin
    acc    = psel && penable && st.pready;
    wr_cmd = acc && pwrite && paddr == `PISC_OFS_CMD;
    sel    = pwdata[`PISC_CMD_SEL];
    code   = pwdata[`PISC_CMD_CODE];
    val    = pwdata[`PISC_CMD_IND] ? st.data : st.oper;
    bad    = 1'b0;
    if (sel > `PISC_SEL_TIMER || (sel < `PISC_SEL_TIMER && 32'(sel) >= NUM_UNITS))
    begin
      bad = 1'b1; // RQ1 RQ20
    end
    if (code > `PISC_CODE_READ)
    begin
      bad = 1'b1; // RQ20
    end
    if (code == `PISC_CODE_READ && pwdata[`PISC_CMD_IMM])
    begin
      bad = 1'b1; // RQ10
    end
    if (pwdata[`PISC_CMD_IMM] && pwdata[`PISC_CMD_IND])
    begin
      bad = 1'b1; // RQ20
    end
    if (pwdata[`PISC_CMD_IND] && (!bcd_ok(st.oper) || bcd2bin(st.oper) > DM_LAST))
    begin
      bad = 1'b1; // RQ21
    end
    if (sel == `PISC_SEL_TIMER && code != `PISC_CODE_READ && !bcd_ok(val))
    begin
      bad = 1'b1; // RQ11 RQ14 RQ20
    end
    cmd_ok = wr_cmd && !bad;
    clr_v  = '0;
    if (cmd_ok && sel < `PISC_SEL_TIMER && code == `PISC_CODE_CLEAR)
    begin
      clr_v[sel[1:0]*8 +: 8] = 8'hff;
    end
  end

  // ==========================================
  // pending selection, lowest routine wins
  always_comb
  begin
    rise    = st.sync2 & ~st.prev; // RQ4
    cand    = st.pend & ~st.mask; // RQ7
    hold_v  = st.pend & st.mask & ~clr_v;
    low_any = |cand;
    low_num = '0;
    for (int i = 31; i >= 0; i--)
    begin
      if (cand[i])
      begin
        low_num = 5'(i); // RQ23
      end
    end
    armed = st.ival_set && st.first_set; // RQ18
    tick  = armed && st.cnt != '0 && st.presc == TICK_LAST; // RQ19 RQ25
  end

  // ==========================================
  // read mux
  always_comb
  begin
    rd = '0;
    case (paddr)
      `PISC_OFS_OPER:   rd = {16'h0000, st.oper};
      `PISC_OFS_DATA:   rd = {16'h0000, st.data};
      `PISC_OFS_RESULT: rd = {16'h0000, st.result};
      `PISC_OFS_STATUS: rd = {19'h00000, st.unit_num, 4'h0, armed, st.sched_act,
                              st.unit_act, st.err};
      `PISC_OFS_COUNT:  rd = {18'h00000, st.cnt};
      `PISC_OFS_MASK:   rd = st.mask;
      `PISC_OFS_PEND:   rd = st.pend;
      default:          rd = '0;
    endcase
  end

  // ==========================================
  // next state
  always_comb
  begin
    n            = st;
    n.svc.go     = 1'b0;
    n.svc.resume = 1'b0;
    n.sync1      = irq_lo;
    n.sync2      = st.sync1;
    n.prev       = st.sync2;
    // apb answers one cycle into the access phase
    n.pready     = psel && penable && !st.pready;
    n.pslverr    = 1'b0;
    if (psel && penable && !st.pready)
    begin
      n.prdata = pwrite ? 32'h00000000 : rd;
      case (paddr)
        `PISC_OFS_CMD, `PISC_OFS_OPER, `PISC_OFS_DATA, `PISC_OFS_RESULT,
        `PISC_OFS_STATUS, `PISC_OFS_COUNT, `PISC_OFS_MASK, `PISC_OFS_PEND:
          n.pslverr = 1'b0;
        default:
          n.pslverr = 1'b1;
      endcase
    end
    if (acc && pwrite && paddr == `PISC_OFS_OPER)
    begin
      n.oper = pwdata[15:0];
    end
    if (acc && pwrite && paddr == `PISC_OFS_DATA)
    begin
      n.data = pwdata[15:0];
    end
    // routine completion ends the innermost active level
    if (svc_done && st.sched_act)
    begin
      n.sched_act = 1'b0;
      if (st.unit_act)
      begin
        n.svc.resume = 1'b1; // RQ22
        n.svc.num    = {2'b00, st.unit_num};
      end
    end
    else if (svc_done)
    begin
      n.unit_act = 1'b0;
    end
    // scheduled request first, it may cut into a unit routine
    if (st.sched_pend && !st.sched_act)
    begin
      n.sched_pend = 1'b0;
      n.sched_act  = 1'b1; // RQ24
      n.svc.go     = 1'b1;
      n.svc.resume = 1'b0;
      n.svc.num    = `PISC_ROUTINE_SCHED;
    end
    else if (low_any && !n.unit_act && !n.sched_act)
    begin
      n.pend[low_num] = 1'b0; // RQ23
      n.unit_act      = 1'b1;
      n.unit_num      = low_num;
      n.svc.go        = 1'b1;
      n.svc.num       = {2'b00, low_num}; // RQ4
    end
    // timer, prescaler runs only while a countdown is live
    if (armed && st.cnt != '0)
    begin
      n.presc = tick ? '0 : st.presc + 24'h000001;
    end
    if (tick)
    begin
      if (st.cnt == 14'h0001)
      begin
        n.sched_pend = 1'b1; // RQ25
        n.cnt        = bcd2bin(st.ival); // RQ13
      end
      else
      begin
        n.cnt = st.cnt - 14'h0001;
      end
    end
    // commands
    if (wr_cmd)
    begin
      n.err = bad; // RQ20
    end
    if (cmd_ok && sel < `PISC_SEL_TIMER)
    begin
      case (code)
        `PISC_CODE_SET:   n.mask[sel[1:0]*8 +: 8] = val[7:0]; // RQ5 RQ3
        `PISC_CODE_CLEAR: n.pend = n.pend & ~clr_v; // RQ8
        `PISC_CODE_READ:  n.result = {8'h00, st.mask[sel[1:0]*8 +: 8]}; // RQ9
        default:          n.result = st.result;
      endcase
    end
    if (cmd_ok && sel == `PISC_SEL_TIMER)
    begin
      case (code)
        `PISC_CODE_SET:
        begin
          n.ival     = val; // RQ11 RQ13
          n.ival_set = 1'b1;
          if (val == '0)
          begin
            n.cnt = '0; // RQ12
          end
        end
        `PISC_CODE_CLEAR:
        begin
          n.first_set = 1'b1;
          n.cnt       = bcd2bin(val); // RQ14 RQ15 RQ16
          n.presc     = '0;
        end
        `PISC_CODE_READ:  n.result = st.ival; // RQ17
        default:          n.result = st.result;
      endcase
    end
    // a new edge beats a same-cycle clear
    n.pend = n.pend | rise; // RQ6
  end

  // ==========================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= n;
    end
  end

  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign prdata     = st.prdata;
  assign svc        = st.svc;
  assign error_flag = st.err;

  // ==========================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sched_done;
    st.sched_act && svc_done && st.unit_act;
  endsequence

  sequence s_unit_go;
    st.svc.go && st.svc.num < 7'd32;
  endsequence

  a_unit_served: assert property (
    s_unit_go |-> ($past(cand) & (32'h1 << st.svc.num[4:0])) != '0) // RQ7
    else $error("unit routine without unmasked pending request");
  a_lowest_first: assert property (
    s_unit_go |-> ($past(cand) & ((32'h1 << st.svc.num[4:0]) - 32'h1)) == '0) // RQ23
    else $error("unit routine not lowest number");
  a_unit_waits: assert property (s_unit_go |-> !$past(st.unit_act) || $past(svc_done)) // RQ23
    else $error("unit routine started while one runs");
  a_masked_kept: assert property (1'b1 |=> ($past(hold_v) & ~st.pend) == '0) // RQ6
    else $error("masked pending request lost");
  a_mask_write: assert property (
    cmd_ok && sel < 4'h4 && code == 4'h0 |=> st.mask[$past(sel[1:0])*8 +: 8] == $past(val[7:0])) // RQ5
    else $error("mask not written");
  a_bad_sel: assert property (wr_cmd && sel > 4'h4 |=> st.err) // RQ20
    else $error("bad selector without error flag");
  a_first_restart: assert property (
    cmd_ok && sel == 4'h4 && code == 4'h1 |=> st.cnt == bcd2bin($past(val)) && st.presc == '0) // RQ15
    else $error("first delay did not restart countdown");
  a_ival_keep: assert property (
    cmd_ok && sel == 4'h4 && code == 4'h0 && val != '0 && !tick |=> st.cnt == $past(st.cnt)) // RQ13
    else $error("interval write altered countdown");
  a_sched_gated: assert property (st.svc.go && st.svc.num == 7'd99 |-> armed) // RQ18
    else $error("scheduled routine before programming");
  a_resume_unit: assert property (
    s_sched_done ##0 !st.sched_pend |=> st.svc.resume && st.svc.num == {2'b00, $past(st.unit_num)}) // RQ22
    else $error("suspended routine not resumed");
  a_fire_go: assert property (
    tick && st.cnt == 14'h0001 && !st.sched_act && !st.sched_pend |=> ##1 st.svc.go) // RQ25
    else $error("scheduled expiry without routine start");
endmodule
`default_nettype wire

// *** src/pisc_pkg.sv ***
// types of the interrupt and schedule controller
// assumes pisc_consts.svh for all numeric constants
`default_nettype none
package pisc_pkg;
  typedef struct packed {
    logic [3:0][15:0] word;
  } pisc_units_t;
  typedef struct packed {
    logic       go;
    logic       resume;
    logic [6:0] num;
  } pisc_svc_t;
  typedef struct packed {
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] prev;
    logic [31:0] mask;
    logic [31:0] pend;
    logic [15:0] oper;
    logic [15:0] data;
    logic [15:0] result;
    logic        err;
    logic [15:0] ival;
    logic        ival_set;
    logic        first_set;
    logic [13:0] cnt;
    logic [23:0] presc;
    logic        sched_pend;
    logic        unit_act;
    logic [4:0]  unit_num;
    logic        sched_act;
    pisc_svc_t   svc;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pisc_state_t;
endpackage
`default_nettype wire
